// *** magnetometer_measure_control.sv ***
`timescale 1ns/100ps
// Functional notes
// RULE1: control two: auto-reset bit7, uncorrected bit5, trigger bit4
// RULE2: rate code picks converter rate, top bit 80 Hz
// RULE3: oversample 16 to 128, output rate halves
// RULE4: auto-reset enabled runs reset before acquisition
// RULE5: auto-reset enable always reads zero
// RULE6: host should write auto-reset enable explicitly
// RULE7: uncorrected select bypasses user offset subtraction
// RULE8: factory calibration always applied to data
// RULE9: trigger write starts a sensor reset cycle
// RULE10: trigger reads one while cycle busy
// RULE11: trigger clears itself when cycle ends
// RULE12: uncorrected select resets to zero
// RULE13: trigger resets to zero
// RULE14: auto-reset enable resets to zero
// RULE15: host changes rate only in standby
// RULE16: offset subtraction is unclipped
// RULE17: unused control two bits read zero
module magnetometer_measure_control
    import meas_ctrl_pkg::*;
#(
    parameter int RST_CYCLES = SENSOR_RST_CYC,
    parameter int ADC_BASE_CYCLES = CLK_HZ / BASE_ADC_HZ // clock cycles per sample at code 000
)(
    input wire logic mclk, // 40 MHz clock
    input wire logic reset, // sync reset, active high
    input wire logic clk_en, // freezes state when low
    input wire reg_req_t req, // register access from host logic
    input wire logic req_valid, // request strobe
    output logic [7:0] rdata, // read data
    input wire logic active, // standby/active selection
    input wire axes_t raw_data, // converter sample
    input wire axes_t factory_cal, // factory offset, always subtracted
    input wire axes_t user_offset, // user offset, lsb forced zero
    output axes_t out_data, // corrected output word
    output logic out_valid, // one-cycle pulse with new output
    output logic sensor_reset_pulse, // high during a sensor reset cycle
    output logic adc_sample // one-cycle converter sample strobe
);
    logic [7:0] ctrl_one;
    logic auto_rst_en;
    logic uncorrected;
    logic oneshot_busy;
    logic [RESET_TICK_BITS-1:0] rst_count;
    seq_state_t state;
    logic [7:0] avg_count;
    logic [31:0] adc_period;
    logic adc_tick;
    logic wr_two;

    initial
    begin
        if (RST_CYCLES < 1 || RST_CYCLES >= (1 << RESET_TICK_BITS))
            $error("reset cycle count out of range");
        // the slowest code shifts the base period left by four
        if (ADC_BASE_CYCLES < 2 || ADC_BASE_CYCLES > (32'h7FFF_FFFF >> 4))
            $error("converter period out of range");
    end

    function automatic logic signed [15:0] corr(input logic signed [15:0] r,
        input logic signed [15:0] f, input logic signed [15:0] u, input logic skip);
        logic signed [15:0] uo;
        uo = {u[15:1], 1'b0};
        // wraps like the device: no saturation
        corr = r - f - (skip ? 16'sh0000 : uo); // RULE7 RULE8 RULE16
    endfunction

    // index of the last sample in an oversample block
    function automatic logic [7:0] block_last(input logic [1:0] os);
        block_last = 8'((BASE_OVS << os) - 1); // RULE3
    endfunction

    assign wr_two = req_valid && req.wr && req.addr == CTRL_TWO_ADDR;

    // rate fields written by the host in standby or active; keeping to standby is left to the host
    always_ff @(posedge mclk)
    begin
        if (reset)
            ctrl_one <= CTRL_RESET;
        else if (clk_en && req_valid && req.wr && req.addr == CTRL_ONE_ADDR)
            ctrl_one <= req.wdata; // RULE15
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            auto_rst_en <= 1'b0; // RULE14
            uncorrected <= 1'b0; // RULE12
        end
        else if (clk_en && wr_two)
        begin
            auto_rst_en <= req.wdata[AUTO_RST_BIT]; // RULE1
            uncorrected <= req.wdata[UNCORR_BIT]; // RULE1
        end
    end

    // converter period: base rate halves per code, codes 4..7 all 80 Hz
    always_comb
    begin
        logic [2:0] rate;
        rate = ctrl_one[RATE_LSB +: 3];
        adc_period = 32'(ADC_BASE_CYCLES) << (rate[2] ? 3'd4 : rate); // RULE2
    end

    sample_divider #(.WIDTH(32)) u_div (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en && active),
        .period(adc_period),
        .tick(adc_tick)
    );

    assign adc_sample = adc_tick && state == ST_ACQ;
    assign sensor_reset_pulse = state == ST_RESET;

    // acquisition sequencer; one-shot trigger and auto reset both win over acquisition start
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            oneshot_busy <= 1'b0; // RULE13
            rst_count <= '0;
            avg_count <= '0;
        end
        else if (clk_en)
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (oneshot_busy || (active && auto_rst_en)) // RULE4
                    begin
                        state <= ST_RESET;
                        rst_count <= RESET_TICK_BITS'(RST_CYCLES - 1);
                    end
                    else if (active)
                        state <= ST_ACQ;
                    avg_count <= '0;
                end
                ST_RESET:
                begin
                    if (rst_count == '0)
                    begin
                        oneshot_busy <= 1'b0; // RULE11
                        state <= active ? ST_ACQ : ST_IDLE;
                    end
                    else
                        rst_count <= rst_count - 1'b1;
                end
                ST_ACQ:
                begin
                    if (!active)
                        state <= ST_IDLE;
                    else if (adc_tick)
                    begin
                        // output once per oversample block
                        if (avg_count == block_last(ctrl_one[OVS_LSB +: 2])) // RULE3
                            state <= ST_IDLE;
                        avg_count <= avg_count + 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // after the case so a trigger in the clearing cycle wins and reruns
            if (wr_two && req.wdata[ONESHOT_BIT])
                oneshot_busy <= 1'b1; // RULE9
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            out_data <= '0;
            out_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            out_valid <= 1'b0;
            if (state == ST_ACQ && adc_tick && active
                && avg_count == block_last(ctrl_one[OVS_LSB +: 2]))
            begin
                out_data.x <= corr(raw_data.x, factory_cal.x, user_offset.x, uncorrected);
                out_data.y <= corr(raw_data.y, factory_cal.y, user_offset.y, uncorrected);
                out_data.z <= corr(raw_data.z, factory_cal.z, user_offset.z, uncorrected);
                out_valid <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            rdata <= '0;
        else if (clk_en && req_valid && !req.wr)
        begin
            if (req.addr == CTRL_TWO_ADDR)
                rdata <= {1'b0, 1'b0, uncorrected, oneshot_busy, 4'h0}; // RULE5 RULE10 RULE17
            else if (req.addr == CTRL_ONE_ADDR)
                rdata <= ctrl_one;
            else
                rdata <= '0;
        end
    end

    a_busy_clears: assert property (@(posedge mclk) disable iff (reset) // RULE11
        clk_en && state == ST_RESET && rst_count == '0 && !(wr_two && req.wdata[ONESHOT_BIT])
        |=> !oneshot_busy || !clk_en)
        else $error("busy not cleared");
    a_trigger_sets: assert property (@(posedge mclk) disable iff (reset) // RULE9
        clk_en && wr_two && req.wdata[ONESHOT_BIT] |=> oneshot_busy)
        else $error("trigger ignored");
    a_auto_hidden: assert property (@(posedge mclk) disable iff (reset) // RULE5
        clk_en && req_valid && !req.wr && req.addr == CTRL_TWO_ADDR |=> !rdata[AUTO_RST_BIT])
        else $error("auto bit visible");
    a_unused_zero: assert property (@(posedge mclk) disable iff (reset) // RULE17
        clk_en && req_valid && !req.wr && req.addr == CTRL_TWO_ADDR |=> rdata[3:0] == 4'h0)
        else $error("unused bits nonzero");
    a_busy_reads: assert property (@(posedge mclk) disable iff (reset) // RULE10
        clk_en && req_valid && !req.wr && req.addr == CTRL_TWO_ADDR && oneshot_busy
        |=> rdata[ONESHOT_BIT])
        else $error("busy not visible");
    a_auto_before: assert property (@(posedge mclk) disable iff (reset) // RULE4
        clk_en && state == ST_IDLE && active && auto_rst_en |=> state == ST_RESET)
        else $error("auto reset skipped");
    a_no_auto: assert property (@(posedge mclk) disable iff (reset) // RULE4
        clk_en && state == ST_IDLE && !oneshot_busy && !auto_rst_en |=> state != ST_RESET)
        else $error("unexpected reset");
    a_raw_path: assert property (@(posedge mclk) disable iff (reset) // RULE7
        out_valid && $past(uncorrected) |-> out_data.x == $past(raw_data.x) - $past(factory_cal.x))
        else $error("raw path corrected");
    a_user_path: assert property (@(posedge mclk) disable iff (reset) // RULE7
        out_valid && !$past(uncorrected) |-> out_data.y == $past(raw_data.y)
            - $past(factory_cal.y) - {$past(user_offset.y[15:1]), 1'b0})
        else $error("user offset not applied");
    c_raw_out: cover property (@(posedge mclk) out_valid && uncorrected);
    c_oneshot: cover property (@(posedge mclk) wr_two && req.wdata[ONESHOT_BIT]);
    c_output: cover property (@(posedge mclk) out_valid);
    c_auto: cover property (@(posedge mclk) state == ST_RESET && auto_rst_en);
endmodule

// *** meas_ctrl_pkg.sv ***
package meas_ctrl_pkg;
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h10;
    localparam logic [7:0] CTRL_TWO_ADDR = 8'h11;
    localparam int AUTO_RST_BIT = 7;
    localparam int UNCORR_BIT = 5;
    localparam int ONESHOT_BIT = 4;
    localparam int RATE_LSB = 5;
    localparam int OVS_LSB = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_TWO_WMASK = 8'hB0;
    // converter base rate and averaging base
    localparam int BASE_ADC_HZ = 1280;
    localparam int BASE_OVS = 16;
    localparam int CLK_HZ = 40_000_000;
    // sensor reset cycle length, arbitrary plain default
    localparam int SENSOR_RST_NS = 1000;
    localparam int SENSOR_RST_CYC = (SENSOR_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RESET_TICK_BITS = 16;

    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } axes_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RESET = 2'b01,
        ST_ACQ = 2'b10
    } seq_state_t;
endpackage

// *** sample_divider.sv ***
`timescale 1ns/100ps
// pulse generator: one tick every period cycles
module sample_divider
    import meas_ctrl_pkg::*;
#(
    parameter int WIDTH = 32
)(
    input wire logic mclk, // clock
    input wire logic reset, // sync reset
    input wire logic clk_en, // clock enable
    input wire logic [WIDTH-1:0] period, // cycles per tick
    output logic tick // one-cycle pulse
);
    logic [WIDTH-1:0] count;

    initial
    begin
        if (WIDTH < 8) $error("divider width too small");
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else if (clk_en)
        begin
            // reload one below the period so ticks come every period cycles;
            // a shrunk period restarts at once instead of wrapping
            if (count == '0 || count >= period)
            begin
                count <= period - 1'b1;
                tick <= 1'b1;
            end
            else
            begin
                count <= count - 1'b1;
                tick <= 1'b0;
            end
        end
    end
endmodule

// *** host_model.sv ***
`timescale 1ns/100ps
module host_model
    import meas_ctrl_pkg::*;
(
    input wire logic mclk, // clock
    output reg_req_t req, // request fields
    output logic req_valid, // request strobe
    input wire logic [7:0] rdata // read data
);
    initial
    begin
        req = '0;
        req_valid = 1'b0;
    end

    // released fields are inverted so a stale request never looks valid
    task automatic release_bus();
        req_valid = 1'b0;
        req = ~req;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge mclk);
        req = '{wr: 1'b1, addr: addr, wdata: data};
        req_valid = 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        release_bus();
    endtask

    // data is taken one and a half cycles after the request edge, where rdata has settled
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge mclk);
        req = '{wr: 1'b0, addr: addr, wdata: 8'h00};
        req_valid = 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        release_bus();
        @(posedge mclk);
        @(negedge mclk);
        data = rdata;
    endtask
endmodule

// *** magnetometer_measure_control_tb_top.sv ***
`timescale 1ns/100ps
`define CHK(name, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch %s expected %0h seen %0h", name, exp, got); end end
module magnetometer_measure_control_tb_top;
    import meas_ctrl_pkg::*;
    localparam int RST_N = 4;
    localparam int ADC_BASE = 100;
    localparam int ADC_LIMIT = 32 * ADC_BASE;
    localparam int OUT_LIMIT = 64 * ADC_BASE;
    // raw minus factory, minus user offset with its lsb forced to zero
    localparam axes_t EXP_CORR = {16'h00EE, 16'h01DC, 16'h02CA};
    localparam axes_t EXP_RAW = {16'h00F0, 16'h01E0, 16'h02D0};
    typedef struct packed {
        logic [7:0] wval;
        logic [7:0] rval;
    } row_t;
    logic mclk, reset, clk_en, active, req_valid, out_valid, sensor_reset_pulse, adc_sample;
    logic [7:0] rdata, rv;
    reg_req_t req;
    axes_t raw_data, factory_cal, user_offset, out_data;
    int failures = 0;
    int samples_checked = 0;
    int pulse_cycles = 0;
    int n;
    row_t rows[4] = '{'{8'h80, 8'h00}, '{8'h20, 8'h20}, '{8'h4F, 8'h00}, '{8'hA0, 8'h20}};

    magnetometer_measure_control #(.RST_CYCLES(RST_N), .ADC_BASE_CYCLES(ADC_BASE)) i_dut (
        .mclk(mclk), .reset(reset),
        .clk_en(clk_en), .req(req), .req_valid(req_valid), .rdata(rdata), .active(active),
        .raw_data(raw_data), .factory_cal(factory_cal), .user_offset(user_offset),
        .out_data(out_data), .out_valid(out_valid), .sensor_reset_pulse(sensor_reset_pulse),
        .adc_sample(adc_sample));
    host_model i_host (.mclk(mclk), .req(req), .req_valid(req_valid), .rdata(rdata));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(negedge mclk)
        if (sensor_reset_pulse === 1'b1)
            pulse_cycles++;

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // counts edges up to the next converter strobe, bounded so a dead divider cannot hang
    task automatic wait_adc(output int cnt);
        cnt = 0;
        do
        begin
            @(negedge mclk);
            cnt++;
        end
        while (adc_sample !== 1'b1 && cnt < ADC_LIMIT);
    endtask

    // counts cycles up to the next output pulse, looked at mid-cycle where it stands
    task automatic wait_out(output int cnt);
        cnt = 0;
        do
        begin
            @(negedge mclk);
            cnt++;
        end
        while (out_valid !== 1'b1 && cnt < OUT_LIMIT);
    endtask

    initial
    begin
        repeat (40000) @(posedge mclk);
        failures++;
        test_done();
    end

    initial
    begin
        reset = 1'b1;
        clk_en = 1'b1;
        active = 1'b0;
        raw_data = {16'h0100, 16'h0200, 16'h0300};
        factory_cal = {16'h0010, 16'h0020, 16'h0030};
        user_offset = {16'h0003, 16'h0004, 16'h0007};
        repeat (8) @(posedge mclk);
        @(negedge mclk) reset = 1'b0;
        i_host.rd(CTRL_TWO_ADDR, rv);
        `CHK("ctrl_two_after_reset", 8'h00, rv)
        $display("test reset done");
        foreach (rows[i])
        begin
            i_host.wr(CTRL_TWO_ADDR, rows[i].wval);
            i_host.rd(CTRL_TWO_ADDR, rv);
            `CHK("ctrl_two_readback", rows[i].rval, rv)
        end
        i_host.rd(8'h12, rv);
        `CHK("unmapped_read", 8'h00, rv)
        @(negedge mclk) clk_en = 1'b0;
        i_host.wr(CTRL_TWO_ADDR, 8'h00);
        clk_en = 1'b1;
        i_host.rd(CTRL_TWO_ADDR, rv);
        `CHK("frozen_write", 8'h20, rv)
        $display("test register map done");
        pulse_cycles = 0;
        i_host.wr(CTRL_TWO_ADDR, 8'h10);
        i_host.rd(CTRL_TWO_ADDR, rv);
        `CHK("oneshot_busy", 8'h10, rv)
        repeat (RST_N + 8) @(negedge mclk);
        i_host.rd(CTRL_TWO_ADDR, rv);
        `CHK("oneshot_cleared", 8'h00, rv)
        `CHK("reset_pulse_cycles", RST_N, pulse_cycles)
        $display("test oneshot done");
        i_host.wr(CTRL_TWO_ADDR, 8'h80);
        i_host.wr(CTRL_ONE_ADDR, 8'h00);
        pulse_cycles = 0;
        @(negedge mclk) active = 1'b1;
        wait_adc(n);
        `CHK("auto_reset_before_acq", 1'b1, pulse_cycles > 0)
        wait_adc(n);
        `CHK("adc_period", ADC_BASE, n)
        wait_out(n);
        `CHK("corrected_out", EXP_CORR, out_data)
        wait_out(n);
        `CHK("output_span_16", 16 * ADC_BASE, n)
        $display("test acquisition done");
        i_host.wr(CTRL_TWO_ADDR, 8'hA0);
        wait_out(n);
        `CHK("raw_out", EXP_RAW, out_data)
        $display("test raw output done");
        @(negedge mclk) active = 1'b0;
        i_host.wr(CTRL_ONE_ADDR, 8'h08);
        @(negedge mclk) active = 1'b1;
        wait_out(n);
        wait_out(n);
        `CHK("output_span_32", 32 * ADC_BASE, n)
        @(negedge mclk) active = 1'b0;
        i_host.wr(CTRL_ONE_ADDR, 8'hE0);
        @(negedge mclk) active = 1'b1;
        wait_adc(n);
        wait_adc(n);
        `CHK("adc_period_top", 16 * ADC_BASE, n)
        $display("test rates done");
        @(negedge mclk) reset = 1'b1;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        i_host.rd(CTRL_TWO_ADDR, rv);
        `CHK("ctrl_two_mid_reset", 8'h00, rv)
        i_host.rd(CTRL_ONE_ADDR, rv);
        `CHK("ctrl_one_mid_reset", 8'h00, rv)
        $display("test mid reset done");
        test_done();
    end
endmodule
